// ==== verilog/ecct_pkg.sv ====
// constants shared by the event capture/compare timer
package ecct_pkg;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CLKSEL = 8'h04;
    localparam logic [7:0] ADDR_CCR = 8'h08;
    localparam logic [7:0] ADDR_EDGE = 8'h0C;
    localparam logic [7:0] ADDR_SMP = 8'h10;
    localparam logic [7:0] ADDR_CMP0 = 8'h14;
    localparam logic [7:0] ADDR_CMP1 = 8'h18;
    localparam logic [7:0] ADDR_CAP = 8'h1C;
    localparam logic [7:0] ADDR_CNT = 8'h20;
    localparam logic [7:0] ADDR_STAT = 8'h24;

    localparam int CTRL_WIDTH_BIT = 0;
    localparam int CTRL_OVF_BIT = 2;
    localparam int CTRL_RUN_BIT = 3;
    localparam int CCR_CLR0_BIT = 0;
    localparam int CCR_CM_BIT = 2;
    localparam int CCR_CLR1_BIT = 3;
    localparam int STAT_PIN_BIT = 0;

    localparam logic [3:0] CLKSEL_RST = 4'h1;
    localparam logic [3:0] CLKSEL_MIN = 4'h1;
    localparam logic [3:0] CLKSEL_MAX = 4'h9;
    localparam logic [3:0] CLKSEL_EXT = 4'hB;
    localparam logic [10:0] PRE_ALL = 11'h7FF;
    localparam logic [3:0] PRE_SHIFT_BASE = 4'h9;

    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_RST = 2'h0;

    localparam logic [1:0] SMP_DIV1 = 2'h0;
    localparam logic [1:0] SMP_DIV64 = 2'h1;
    localparam logic [1:0] SMP_DIV128 = 2'h2;
    localparam logic [7:0] SMP_MASK1 = 8'h00;
    localparam logic [7:0] SMP_MASK64 = 8'h3F;
    localparam logic [7:0] SMP_MASK128 = 8'h7F;
    localparam logic [7:0] SMP_MASK256 = 8'hFF;
    localparam int FILT_LEN = 3;

    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [7:0] CNT8_MAX = 8'hFF;
    localparam logic [15:0] CNT16_MAX = 16'hFFFF;

    typedef enum logic {ECCT_BUS_IDLE, ECCT_BUS_RD} ecct_bus_st_t;

endpackage : ecct_pkg

// ==== verilog/ecct_prescale.sv ====
// internal count clock divider, one-cycle tick per period
`timescale 1ns/1ps
`default_nettype none
module ecct_prescale (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] sel_in,
    output logic tick_out
);

    logic [10:0] div_ff;
    logic [10:0] nxt_div;
    logic tick_ff;
    logic nxt_tick;
    logic [10:0] mask;

    // sel 1..9 gives divide by 8..2048
    function automatic logic [10:0] div_mask(input logic [3:0] sel);
        div_mask = ecct_pkg::PRE_ALL >> (ecct_pkg::PRE_SHIFT_BASE - sel);
    endfunction : div_mask

    always_comb
    begin
        mask = div_mask(sel_in);
        nxt_div = div_ff + 11'h001;
        nxt_tick = (sel_in >= ecct_pkg::CLKSEL_MIN) && (sel_in <= ecct_pkg::CLKSEL_MAX)
            && ((div_ff & mask) == mask);
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            div_ff <= 11'h000;
            tick_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_out = tick_ff;

endmodule : ecct_prescale
`default_nettype wire

// ==== verilog/ecct_edge.sv ====
// pin synchroniser, sampled level filter and edge selector
`timescale 1ns/1ps
`default_nettype none
module ecct_edge (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    input wire logic [1:0] smp_sel_in,
    input wire logic [1:0] edge_sel_in,
    output logic edge_out
);

    localparam int FL = ecct_pkg::FILT_LEN;

    logic sync1_ff;
    logic sync2_ff;
    logic [7:0] smp_ff;
    logic [7:0] nxt_smp;
    logic [FL-1:0] hist_ff;
    logic [FL-1:0] nxt_hist;
    logic level_ff;
    logic nxt_level;
    logic edge_ff;
    logic nxt_edge;
    logic [7:0] m;
    logic rise;
    logic fall;

    function automatic logic [7:0] smp_mask(input logic [1:0] sel);
        if (sel == ecct_pkg::SMP_DIV1)
            smp_mask = ecct_pkg::SMP_MASK1;
        else if (sel == ecct_pkg::SMP_DIV64)
            smp_mask = ecct_pkg::SMP_MASK64;
        else if (sel == ecct_pkg::SMP_DIV128)
            smp_mask = ecct_pkg::SMP_MASK128;
        else
            smp_mask = ecct_pkg::SMP_MASK256;
    endfunction : smp_mask

    always_comb
    begin
        m = smp_mask(smp_sel_in);
        nxt_smp = smp_ff + 8'h01;
        nxt_hist = hist_ff;
        // level only accepted after three equal samples
        if ((smp_ff & m) == m)
            nxt_hist = {hist_ff[FL-2:0], sync2_ff};
        nxt_level = level_ff;
        if (&nxt_hist)
            nxt_level = 1'b1;
        else if (~|nxt_hist)
            nxt_level = 1'b0;
        rise = nxt_level & ~level_ff;
        fall = ~nxt_level & level_ff;
        nxt_edge = ((edge_sel_in == ecct_pkg::EDGE_RISE) & rise)
            | ((edge_sel_in == ecct_pkg::EDGE_FALL) & fall)
            | ((edge_sel_in == ecct_pkg::EDGE_BOTH) & (rise | fall));
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            smp_ff <= 8'h00;
            hist_ff <= '0;
            level_ff <= 1'b0;
            edge_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            smp_ff <= nxt_smp;
            hist_ff <= nxt_hist;
            level_ff <= nxt_level;
            edge_ff <= nxt_edge;
        end
    end

    assign edge_out = edge_ff;

endmodule : ecct_edge
`default_nettype wire

// ==== verilog/ecct_timer.sv ====
// event capture/compare timer with ahb-lite register slave
// Contract
// - run set before next count clock after stop: that clock starts at 0
// - run set later: counting from 0 begins with following count clocks
// - external event counting chosen only by the clock select code
// - input rate limit set by sampling clock alone, any edge choice
// - run set from 0: counter 0, next count clock loads 0, increments from the one after
// - run cleared: counter forced to 0 at once, stopped
// - writing run 1 while running leaves counting untouched
// - counter equal to compare value on increment raises match request
// - optional clear after match makes an interval timer
// - trigger edge copies count to capture reg, shared reg in capture mode
// - capture registers hold value until next trigger
// - trigger edge rising, falling or both per edge configuration
// - shared capture with clear enabled clears counter after capture
// - capture clear loads 0 where N+1 would be; a compare at N+1 still matches
// - mode bit 0 compare, 1 capture for shared register
// - two independent compare registers on one counter
// - wrap at FF or FFFF sets overflow flag, software clears it
// - clear source takes effect on next count clock only
// - width bit 0 selects 8-bit or 16-bit counting
// - separate clear enables for first and shared register events
`timescale 1ns/1ps
`default_nettype none
module ecct_timer (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic [31:0] hrdata_out,
    output logic hresp_out,
    input wire logic external_event_pin_in,
    output logic first_match_irq_out,
    output logic shared_match_irq_out,
    output logic edge_irq_out
);

    ecct_pkg::ecct_bus_st_t st_ff;
    ecct_pkg::ecct_bus_st_t nxt_st;
    logic [7:0] addr_ff;
    logic [7:0] nxt_addr;
    logic wr_pend_ff;
    logic nxt_wr_pend;
    logic hready_ff;
    logic nxt_hready;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_hrdata;
    logic [31:0] rd_word;
    logic acc;

    logic width_ff;
    logic nxt_width;
    logic ovf_ff;
    logic nxt_ovf;
    logic run_ff;
    logic nxt_run;
    logic [3:0] clksel_ff;
    logic [3:0] nxt_clksel;
    logic cm_ff;
    logic nxt_cm;
    logic clr0_ff;
    logic nxt_clr0;
    logic clr1_ff;
    logic nxt_clr1;
    logic [1:0] edgecfg_ff;
    logic [1:0] nxt_edgecfg;
    logic [1:0] smpsel_ff;
    logic [1:0] nxt_smpsel;
    logic [15:0] cmp0_ff;
    logic [15:0] nxt_cmp0;
    logic [15:0] cmp1_ff;
    logic [15:0] nxt_cmp1;
    logic [15:0] cap_ff;
    logic [15:0] nxt_cap;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic start_ff;
    logic nxt_start;
    logic clrp_ff;
    logic nxt_clrp;
    logic pinflag_ff;
    logic nxt_pinflag;
    logic irq0_ff;
    logic irq1_ff;
    logic eirq_ff;

    logic pre_tick;
    logic edge_pulse;
    logic tick;
    logic counting;
    logic [15:0] inc16;
    logic [15:0] inc;
    logic wrap;
    logic match0;
    logic match1;
    logic cap_ev;
    logic clr_src;
    logic we;
    logic [31:0] w;

    ecct_prescale u_pre (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .sel_in(clksel_ff),
        .tick_out(pre_tick)
    );

    ecct_edge u_edge (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(external_event_pin_in),
        .smp_sel_in(smpsel_ff),
        .edge_sel_in(edgecfg_ff),
        .edge_out(edge_pulse)
    );

    // compare value seen at the selected width
    function automatic logic [15:0] at_width(input logic wide, input logic [15:0] v);
        at_width = wide ? v : {8'h00, v[7:0]};
    endfunction : at_width

    // bus: writes zero wait, reads one wait state
    always_comb
    begin
        acc = hsel_in & htrans_in[1] & hready_in;
        nxt_st = st_ff;
        nxt_addr = addr_ff;
        nxt_wr_pend = 1'b0;
        nxt_hready = 1'b1;
        nxt_hrdata = hrdata_ff;
        case (st_ff)
            ecct_pkg::ECCT_BUS_IDLE:
            begin
                if (acc)
                begin
                    nxt_addr = haddr_in[7:0];
                    nxt_wr_pend = hwrite_in;
                    if (!hwrite_in)
                    begin
                        nxt_st = ecct_pkg::ECCT_BUS_RD;
                        nxt_hready = 1'b0;
                    end
                end
            end
            ecct_pkg::ECCT_BUS_RD:
            begin
                nxt_hrdata = rd_word;
                nxt_st = ecct_pkg::ECCT_BUS_IDLE;
            end
            default:
            begin
                nxt_st = ecct_pkg::ECCT_BUS_IDLE;
            end
        endcase
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (addr_ff == ecct_pkg::ADDR_CTRL)
            rd_word = {28'h000_0000, run_ff, ovf_ff, 1'b0, width_ff};
        else if (addr_ff == ecct_pkg::ADDR_CLKSEL)
            rd_word = {28'h000_0000, clksel_ff};
        else if (addr_ff == ecct_pkg::ADDR_CCR)
            rd_word = {28'h000_0000, clr1_ff, cm_ff, 1'b0, clr0_ff};
        else if (addr_ff == ecct_pkg::ADDR_EDGE)
            rd_word = {30'h0000_0000, edgecfg_ff};
        else if (addr_ff == ecct_pkg::ADDR_SMP)
            rd_word = {30'h0000_0000, smpsel_ff};
        else if (addr_ff == ecct_pkg::ADDR_CMP0)
            rd_word = {16'h0000, cmp0_ff};
        else if (addr_ff == ecct_pkg::ADDR_CMP1)
            rd_word = {16'h0000, cmp1_ff};
        else if (addr_ff == ecct_pkg::ADDR_CAP)
            rd_word = {16'h0000, cap_ff};
        else if (addr_ff == ecct_pkg::ADDR_CNT)
            rd_word = {16'h0000, cnt_ff};
        else if (addr_ff == ecct_pkg::ADDR_STAT)
            rd_word = {31'h0000_0000, pinflag_ff};
    end

    // registers and counter
    always_comb
    begin
        we = wr_pend_ff;
        w = hwdata_in;
        tick = (clksel_ff == ecct_pkg::CLKSEL_EXT) ? edge_pulse : pre_tick;
        counting = run_ff & tick & ~start_ff;
        inc16 = cnt_ff + 16'h0001;
        inc = at_width(width_ff, inc16);
        wrap = width_ff ? (cnt_ff == ecct_pkg::CNT16_MAX)
            : (cnt_ff[7:0] == ecct_pkg::CNT8_MAX);
        match0 = counting & (inc == at_width(width_ff, cmp0_ff));
        match1 = counting & ~cm_ff & (inc == at_width(width_ff, cmp1_ff));
        cap_ev = edge_pulse & run_ff;
        clr_src = (match0 & clr0_ff) | (match1 & clr1_ff) | (cap_ev & cm_ff & clr1_ff);
        nxt_width = width_ff;
        nxt_ovf = ovf_ff;
        nxt_run = run_ff;
        nxt_clksel = clksel_ff;
        nxt_cm = cm_ff;
        nxt_clr0 = clr0_ff;
        nxt_clr1 = clr1_ff;
        nxt_edgecfg = edgecfg_ff;
        nxt_smpsel = smpsel_ff;
        nxt_cmp0 = cmp0_ff;
        nxt_cmp1 = cmp1_ff;
        nxt_cap = cap_ff;
        nxt_cnt = cnt_ff;
        nxt_start = start_ff;
        nxt_clrp = clrp_ff;
        nxt_pinflag = pinflag_ff;
        if (we && addr_ff == ecct_pkg::ADDR_CTRL)
        begin
            nxt_width = w[ecct_pkg::CTRL_WIDTH_BIT];
            nxt_run = w[ecct_pkg::CTRL_RUN_BIT];
            if (!w[ecct_pkg::CTRL_OVF_BIT])
                nxt_ovf = 1'b0;
            if (w[ecct_pkg::CTRL_RUN_BIT] && !run_ff)
                nxt_start = 1'b1;
        end
        if (we && addr_ff == ecct_pkg::ADDR_CLKSEL)
            nxt_clksel = w[3:0];
        if (we && addr_ff == ecct_pkg::ADDR_CCR)
        begin
            nxt_clr0 = w[ecct_pkg::CCR_CLR0_BIT];
            nxt_cm = w[ecct_pkg::CCR_CM_BIT];
            nxt_clr1 = w[ecct_pkg::CCR_CLR1_BIT];
        end
        if (we && addr_ff == ecct_pkg::ADDR_EDGE)
            nxt_edgecfg = w[1:0];
        if (we && addr_ff == ecct_pkg::ADDR_SMP)
            nxt_smpsel = w[1:0];
        if (we && addr_ff == ecct_pkg::ADDR_CMP0)
            nxt_cmp0 = w[15:0];
        if (we && addr_ff == ecct_pkg::ADDR_CMP1 && !cm_ff)
            nxt_cmp1 = w[15:0];
        if (we && addr_ff == ecct_pkg::ADDR_STAT && w[ecct_pkg::STAT_PIN_BIT])
            nxt_pinflag = 1'b0;
        if (edge_pulse)
            nxt_pinflag = 1'b1;
        if (run_ff && tick)
        begin
            if (start_ff)
            begin
                nxt_cnt = ecct_pkg::CNT_RST;
                nxt_start = 1'b0;
            end
            else
            begin
                // loads 0 instead of inc, but a compare at N+1 still fires
                nxt_cnt = clrp_ff ? ecct_pkg::CNT_RST : inc;
                nxt_clrp = 1'b0;
                if (wrap && !clrp_ff)
                    nxt_ovf = 1'b1;
            end
        end
        if (clr_src)
            nxt_clrp = 1'b1;
        if (cap_ev)
        begin
            nxt_cap = cnt_ff;
            if (cm_ff)
                nxt_cmp1 = cnt_ff;
        end
        if (!nxt_run)
        begin
            nxt_cnt = ecct_pkg::CNT_RST;
            nxt_start = 1'b0;
            nxt_clrp = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_ff <= ecct_pkg::ECCT_BUS_IDLE;
            addr_ff <= 8'h00;
            wr_pend_ff <= 1'b0;
            hready_ff <= 1'b1;
            hrdata_ff <= 32'h0000_0000;
            width_ff <= 1'b0;
            ovf_ff <= 1'b0;
            run_ff <= 1'b0;
            clksel_ff <= ecct_pkg::CLKSEL_RST;
            cm_ff <= 1'b0;
            clr0_ff <= 1'b0;
            clr1_ff <= 1'b0;
            edgecfg_ff <= ecct_pkg::EDGE_RST;
            smpsel_ff <= ecct_pkg::SMP_DIV1;
            cmp0_ff <= 16'h0000;
            cmp1_ff <= 16'h0000;
            cap_ff <= 16'h0000;
            cnt_ff <= ecct_pkg::CNT_RST;
            start_ff <= 1'b0;
            clrp_ff <= 1'b0;
            pinflag_ff <= 1'b0;
            irq0_ff <= 1'b0;
            irq1_ff <= 1'b0;
            eirq_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            addr_ff <= nxt_addr;
            wr_pend_ff <= nxt_wr_pend;
            hready_ff <= nxt_hready;
            hrdata_ff <= nxt_hrdata;
            width_ff <= nxt_width;
            ovf_ff <= nxt_ovf;
            run_ff <= nxt_run;
            clksel_ff <= nxt_clksel;
            cm_ff <= nxt_cm;
            clr0_ff <= nxt_clr0;
            clr1_ff <= nxt_clr1;
            edgecfg_ff <= nxt_edgecfg;
            smpsel_ff <= nxt_smpsel;
            cmp0_ff <= nxt_cmp0;
            cmp1_ff <= nxt_cmp1;
            cap_ff <= nxt_cap;
            cnt_ff <= nxt_cnt;
            start_ff <= nxt_start;
            clrp_ff <= nxt_clrp;
            pinflag_ff <= nxt_pinflag;
            irq0_ff <= match0;
            irq1_ff <= match1;
            eirq_ff <= edge_pulse;
        end
    end

    assign hreadyout_out = hready_ff;
    assign hrdata_out = hrdata_ff;
    assign hresp_out = 1'b0;
    assign first_match_irq_out = irq0_ff;
    assign shared_match_irq_out = irq1_ff;
    assign edge_irq_out = eirq_ff;

    property p_stop_zero;
        @(posedge clk_in) disable iff (rst_in)
        !run_ff |-> cnt_ff == ecct_pkg::CNT_RST;
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("count not zero while stopped");

    property p_start;
        @(posedge clk_in) disable iff (rst_in)
        $rose(run_ff) |-> start_ff && cnt_ff == ecct_pkg::CNT_RST;
    endproperty
    a_start: assert property (p_start) else $error("start did not arm from zero");

    property p_hold;
        @(posedge clk_in) disable iff (rst_in)
        run_ff && $past(run_ff) && !$past(tick) |-> $stable(cnt_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without a count clock");

    property p_match0;
        @(posedge clk_in) disable iff (rst_in)
        counting && inc == at_width(width_ff, cmp0_ff) |=> first_match_irq_out;
    endproperty
    a_match0: assert property (p_match0) else $error("first match request missing");

    property p_wrap;
        @(posedge clk_in) disable iff (rst_in)
        counting && wrap && !clrp_ff && nxt_run |=> ovf_ff && cnt_ff == ecct_pkg::CNT_RST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not set overflow");

    property p_clr_wait;
        @(posedge clk_in) disable iff (rst_in)
        clrp_ff && !tick && run_ff ##1 run_ff |-> $stable(cnt_ff);
    endproperty
    a_clr_wait: assert property (p_clr_wait) else $error("clear before count clock");

    property p_cap;
        @(posedge clk_in) disable iff (rst_in)
        cap_ev |=> cap_ff == $past(cnt_ff);
    endproperty
    a_cap: assert property (p_cap) else $error("capture value wrong");

    property p_cap_hold;
        @(posedge clk_in) disable iff (rst_in)
        !cap_ev |=> $stable(cap_ff);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture changed");

    property p_pulse;
        @(posedge clk_in) disable iff (rst_in)
        first_match_irq_out |=> !first_match_irq_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("match request longer than one cycle");

endmodule : ecct_timer
`default_nettype wire

// ==== sim/ecct_pulse_src.sv ====
// pulse source that toggles the event pin a set number of times
`timescale 1ns/1ps
`default_nettype none
module ecct_pulse_src (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [7:0] edges_in,
    input wire logic [7:0] width_in,
    output logic pin_out,
    output logic busy_out
);
    logic [7:0] left_ff = 8'h00;
    logic [7:0] wid_ff = 8'h03;
    logic [7:0] hold_ff = 8'h00;
    assign busy_out = (left_ff != 8'h00);
    initial pin_out = 1'b0;
    always @(posedge clk_in)
    begin
        if (start_in && !busy_out)
        begin
            left_ff <= edges_in;
            wid_ff <= (width_in < 8'h03) ? 8'h03 : width_in;
            hold_ff <= 8'h01;
        end
        else if (busy_out)
        begin
            hold_ff <= hold_ff + 8'h01;
            if (hold_ff >= wid_ff)
            begin
                pin_out <= ~pin_out;
                left_ff <= left_ff - 8'h01;
                hold_ff <= 8'h01;
            end
        end
    end
endmodule : ecct_pulse_src
`default_nettype wire

// ==== sim/ecct_timer_tb.sv ====
// self-checking bench for the event capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module event_capture_compare_timer_tb_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic pin;
    logic irq0;
    logic irq1;
    logic irqe;
    logic start = 1'b0;
    logic [7:0] edges = 8'h00;
    logic [7:0] width = 8'h03;
    logic busy;
    logic [31:0] v;
    logic [31:0] c1;
    int fail_count = 0;
    int n_compared = 0;
    int n0 = 0;
    int n1 = 0;
    int ne = 0;

    ecct_timer dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hreadyout_out(hready), .hrdata_out(hrdata), .hresp_out(hresp),
        .external_event_pin_in(pin), .first_match_irq_out(irq0),
        .shared_match_irq_out(irq1), .edge_irq_out(irqe));
    ecct_pulse_src src (.clk_in(clk_in), .start_in(start), .edges_in(edges),
        .width_in(width), .pin_out(pin), .busy_out(busy));

    initial
    begin
        forever #50 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        if (irq0 === 1'b1) n0 <= n0 + 1;
        if (irq1 === 1'b1) n1 <= n1 + 1;
        if (irqe === 1'b1) ne <= ne + 1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge clk_in); while (hready !== 1'b1 && i++ < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_in); while (hready !== 1'b1 && i++ < 200);
        v = hrdata;
        if (i >= 100) fail_count++;
    endtask : ahb

    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        check(what, v, exp);
    endtask : rc

    task automatic pulses(input logic [7:0] n, input logic [7:0] w);
        int i;
        i = 0;
        edges <= n;
        width <= w;
        start <= 1'b1;
        @(posedge clk_in);
        start <= 1'b0;
        do @(posedge clk_in); while (busy === 1'b1 && i++ < 5000);
        if (i >= 5000) fail_count++;
        // edge path latency through sync and filter
        repeat (12) @(posedge clk_in);
    endtask : pulses

    task automatic t_reset();
        rc("ctrl", ecct_pkg::ADDR_CTRL, 32'h0000_0000);
        rc("count", ecct_pkg::ADDR_CNT, 32'h0000_0000);
        rc("clksel", ecct_pkg::ADDR_CLKSEL, 32'h0000_0001);
        ahb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        rc("unmapped", 8'h3C, 32'h0000_0000);
        check("hresp", {31'h0, hresp}, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_events();
        int c;
        int e;
        int k;
        ahb(1'b1, ecct_pkg::ADDR_CLKSEL, 32'h0000_000B);
        for (c = 0; c < 4; c++)
        begin
            ahb(1'b1, ecct_pkg::ADDR_EDGE, 32'(c));
            ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0008);
            e = (c == 2) ? 8 : ((c == 3) ? 0 : 4);
            ahb(1'b1, ecct_pkg::ADDR_STAT, 32'h0000_0001);
            k = ne;
            pulses(8'h08, 8'h03);
            rc("event count", ecct_pkg::ADDR_CNT, 32'((e == 0) ? 0 : e - 1));
            check("edge irqs", 32'(ne - k), 32'(e));
            rc("pin flag", ecct_pkg::ADDR_STAT, 32'(e != 0));
            ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0000);
            rc("stopped", ecct_pkg::ADDR_CNT, 32'h0000_0000);
        end
        $display("test events done");
    endtask : t_events

    task automatic t_compare();
        int k;
        int j;
        ahb(1'b1, ecct_pkg::ADDR_EDGE, 32'h0000_0002);
        pulses(8'h02, 8'h03);
        ahb(1'b1, ecct_pkg::ADDR_CMP0, 32'h0000_0003);
        ahb(1'b1, ecct_pkg::ADDR_CMP1, 32'h0000_0002);
        ahb(1'b1, ecct_pkg::ADDR_CCR, 32'h0000_0001);
        ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0008);
        k = n0;
        j = n1;
        pulses(8'h03, 8'h03);
        rc("before rerun", ecct_pkg::ADDR_CNT, 32'h0000_0002);
        ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0008);
        pulses(8'h01, 8'h03);
        rc("held at match", ecct_pkg::ADDR_CNT, 32'h0000_0003);
        pulses(8'h06, 8'h03);
        rc("after clears", ecct_pkg::ADDR_CNT, 32'h0000_0001);
        check("first irqs", 32'(n0 - k), 32'h0000_0002);
        check("shared irqs", 32'(n1 - j), 32'h0000_0002);
        ahb(1'b1, ecct_pkg::ADDR_CCR, 32'h0000_000C);
        k = n0;
        pulses(8'h02, 8'h03);
        rc("capture at two", ecct_pkg::ADDR_CAP, 32'h0000_0002);
        rc("shared at two", ecct_pkg::ADDR_CMP1, 32'h0000_0002);
        rc("cleared", ecct_pkg::ADDR_CNT, 32'h0000_0000);
        check("match n plus one", 32'(n0 - k), 32'h0000_0001);
        ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0000);
        $display("test compare done");
    endtask : t_compare

    task automatic t_capture();
        ahb(1'b1, ecct_pkg::ADDR_CLKSEL, 32'h0000_0001);
        ahb(1'b1, ecct_pkg::ADDR_EDGE, 32'h0000_0001);
        ahb(1'b1, ecct_pkg::ADDR_CCR, 32'h0000_0004);
        ahb(1'b1, ecct_pkg::ADDR_SMP, 32'h0000_0001);
        ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0009);
        pulses(8'h02, 8'hC8);
        ahb(1'b0, ecct_pkg::ADDR_CAP, 32'h0000_0000);
        c1 = v;
        rc("shared capture", ecct_pkg::ADDR_CMP1, c1);
        check("capture nonzero", 32'(c1 > 32'h0000_0000), 32'h0000_0001);
        repeat (200) @(posedge clk_in);
        rc("capture held", ecct_pkg::ADDR_CAP, c1);
        ahb(1'b1, ecct_pkg::ADDR_SMP, 32'h0000_0000);
        ahb(1'b1, ecct_pkg::ADDR_CCR, 32'h0000_0000);
        ahb(1'b1, ecct_pkg::ADDR_CMP1, 32'h0000_0055);
        pulses(8'h02, 8'h64);
        ahb(1'b0, ecct_pkg::ADDR_CAP, 32'h0000_0000);
        check("capture grows", 32'(v > c1), 32'h0000_0001);
        rc("compare kept", ecct_pkg::ADDR_CMP1, 32'h0000_0055);
        ahb(1'b1, ecct_pkg::ADDR_CCR, 32'h0000_000C);
        pulses(8'h02, 8'h64);
        ahb(1'b0, ecct_pkg::ADDR_CAP, 32'h0000_0000);
        c1 = v;
        ahb(1'b0, ecct_pkg::ADDR_CNT, 32'h0000_0000);
        check("capture clear", 32'(v < c1 && v < 32'd40), 32'h0000_0001);
        ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0000);
        $display("test capture done");
    endtask : t_capture

    task automatic t_clk();
        int s;
        for (s = 1; s <= 9; s++)
        begin
            ahb(1'b1, ecct_pkg::ADDR_CLKSEL, 32'(s));
            ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0009);
            repeat (5 << (s + 2)) @(posedge clk_in);
            ahb(1'b0, ecct_pkg::ADDR_CNT, 32'h0000_0000);
            check("divided count", 32'(v >= 32'd3 && v <= 32'd5), 32'h0000_0001);
            ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0000);
        end
        $display("test clock select done");
    endtask : t_clk

    task automatic t_ovf();
        ahb(1'b1, ecct_pkg::ADDR_CLKSEL, 32'h0000_0001);
        ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0008);
        repeat (2080) @(posedge clk_in);
        rc("overflow set", ecct_pkg::ADDR_CTRL, 32'h0000_000C);
        ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0008);
        rc("overflow cleared", ecct_pkg::ADDR_CTRL, 32'h0000_0008);
        ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0000);
        ahb(1'b1, ecct_pkg::ADDR_CTRL, 32'h0000_0009);
        repeat (2080) @(posedge clk_in);
        rc("wide no overflow", ecct_pkg::ADDR_CTRL, 32'h0000_0009);
        ahb(1'b0, ecct_pkg::ADDR_CNT, 32'h0000_0000);
        check("wide count", 32'(v > 32'h0000_00FF), 32'h0000_0001);
        $display("test overflow done");
    endtask : t_ovf

    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_events();
        t_compare();
        t_capture();
        t_clk();
        t_ovf();
        stop_test();
    end

    initial
    begin
        #6_000_000;
        fail_count++;
        stop_test();
    end
endmodule : event_capture_compare_timer_tb_top
`default_nettype wire
